// [include/remc_pkg.sv]
/*
  Constants, codes and state encoding for the regulator enable and
  multifunction pin control block.
  Assumes a single 50 MHz clock domain; times become cycle counts here.
*/
package remc_pkg;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int CLK_MHZ         = 50;
  localparam int BIAS_SETTLE_US  = 100;
  localparam int SOFT_START_US   = 800;
  localparam int OC_PERSIST_MS   = 3;
  localparam int BIAS_SETTLE_CYC = BIAS_SETTLE_US * CLK_MHZ;
  localparam int SOFT_START_CYC  = SOFT_START_US * CLK_MHZ;
  localparam int OC_PERSIST_CYC  = OC_PERSIST_MS * 1000 * CLK_MHZ;
  localparam int TMR_W           = 18;

  // ********************************************************************
  // field widths and pin function codes
  // ********************************************************************
  localparam int LIM_W   = 2;
  localparam int LEVEL_W = 7;
  localparam int FUNC_W  = 3;
  localparam int FLAG_W  = 4;

  localparam logic [FUNC_W-1:0] FUNC_PWM   = 3'h1;
  localparam logic [FUNC_W-1:0] FUNC_LIMIT = 3'h2;
  localparam logic [FUNC_W-1:0] FUNC_LEVEL = 3'h3;
  localparam logic [FUNC_W-1:0] FUNC_GOOD  = 3'h4;
  localparam logic [FUNC_W-1:0] FUNC_INT   = 3'h5;

  // interrupt flag positions
  localparam int FLAG_OV   = 0;
  localparam int FLAG_OC   = 1;
  localparam int FLAG_GOOD = 2;
  localparam int FLAG_TEMP = 3;

  // ********************************************************************
  // values after reset and limit pin codes
  // ********************************************************************
  localparam logic                RST_REG_ON = 1'h1;
  localparam logic                RST_FORCED_PWM_MODE   = 1'h0;
  localparam logic [LIM_W-1:0]    RST_LIM    = 2'h3;
  localparam logic [LEVEL_W-1:0]  RST_LOW    = 7'h00;
  localparam logic [LEVEL_W-1:0]  RST_HIGH   = 7'h00;
  localparam logic [FUNC_W-1:0]   RST_FUNC   = 3'h1;
  localparam logic [FLAG_W-1:0]   RST_MASK   = 4'h0;
  localparam logic [LIM_W-1:0]    LIM_CODE_LOW  = 2'h0;
  localparam logic [LIM_W-1:0]    LIM_CODE_HIGH = 2'h3;

  // ********************************************************************
  // sequencer states
  // ********************************************************************
  typedef enum logic [5:0] {
    ST_OFF  = 6'h01,
    ST_BIAS = 6'h02,
    ST_IDLE = 6'h04,
    ST_SOFT = 6'h08,
    ST_RUN  = 6'h10,
    ST_TRIP = 6'h20
  } remc_state_e;

endpackage : remc_pkg

// [include/remc_tmr_if.sv]
/*
  Start and done pair between the sequencer and one interval timer.
  Assumes both ends share the block clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface remc_tmr_if;
  logic run;
  logic done;
  modport ctl (output run, input done);
  modport tmr (input run, output done);
endinterface : remc_tmr_if
`default_nettype wire

// [logic/remc_timer.sv]
/*
  Interval timer: done rises CYCLES edges after run goes high and
  stays high while run stays high.
  Assumes run is synchronous to clk; dropping run restarts the count.
*/
`timescale 1ns/100ps
`default_nettype none
module remc_timer
  import remc_pkg::*;
#(
  parameter int CYCLES = 16
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  remc_tmr_if.tmr   tif
);

  localparam logic [TMR_W-1:0] LAST = TMR_W'(CYCLES - 1);

  logic [TMR_W-1:0] cnt_r;
  logic             done_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (!tif.run) begin
      cnt_r <= '0;
    end else if (cnt_r != LAST) begin
      cnt_r <= cnt_r + TMR_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= tif.run && (done_r || cnt_r == LAST);
    end
  end

  assign tif.done = done_r;

endmodule : remc_timer
`default_nettype wire

// [logic/remc_top.sv]
/*
  Enable sequencing, protective shut-off and multifunction pin control
  of a step-up/step-down regulator.
  Assumes an outside I2C engine turns host accesses into the strobes
  below, and that the analog stage reports its hazards as levels.
*/
`timescale 1ns/100ps
`default_nettype none
module remc_top
  import remc_pkg::*;
#(
  parameter int                 BIAS_CYC    = BIAS_SETTLE_CYC,
  parameter int                 SOFT_CYC    = SOFT_START_CYC,
  parameter int                 OC_CYC      = OC_PERSIST_CYC,
  parameter logic [FUNC_W-1:0]  FUNC_DEF    = RST_FUNC,
  parameter logic [LIM_W-1:0]   LIM_LOW     = LIM_CODE_LOW,
  parameter logic [LIM_W-1:0]   LIM_HIGH    = LIM_CODE_HIGH
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // enable pin and hazard levels
  input  wire logic                enPin,
  input  wire logic                overTemp,
  input  wire logic                supplyLow,
  input  wire logic                limitHit,
  input  wire logic                overVolt,
  input  wire logic                aboveGoodRise,
  input  wire logic                belowGoodFall,
  // host configuration write
  input  wire logic                cfgWrite,
  input  wire logic                regulationOnBit,
  input  wire logic                forcedPwmBit,
  input  wire logic [LIM_W-1:0]    switchPeakLimit,
  input  wire logic [LEVEL_W-1:0]  levelLowSetting,
  input  wire logic [LEVEL_W-1:0]  levelHighSetting,
  input  wire logic [FUNC_W-1:0]   pinFuncSel,
  input  wire logic [FLAG_W-1:0]   intMaskIn,
  // host flag read
  input  wire logic                flagReadStart,
  input  wire logic                flagReadDone,
  output logic      [FLAG_W-1:0]   flagReadData_r,
  // I2C pin gating
  input  wire logic                sdaDriveLow,
  output logic                     sdaOut_r,
  output logic                     sdaOeN_r,
  output logic                     sclOeN_r,
  // multifunction pin
  input  wire logic                mfpIn,
  output logic                     mfpOut_r,
  output logic                     mfpOeN_r,
  output logic                     mfpPullDown_r,
  // regulator control and status
  output logic                     accessReady_r,
  output logic                     biasOn_r,
  output logic                     regulatorOn_r,
  output logic                     softStartDone_r,
  output logic                     forcedPwmMode_r,
  output logic      [LIM_W-1:0]    peakLimitSelect_r,
  output logic      [LEVEL_W-1:0]  targetLevel_r,
  output logic                     outputGood_r
);

  // ********************************************************************
  // timers
  // ********************************************************************
  remc_tmr_if tBias ();
  remc_tmr_if tSoft ();
  remc_tmr_if tOc ();

  remc_timer #(.CYCLES(BIAS_CYC)) uBias (.clk(clk), .rst(rst), .tif(tBias));
  remc_timer #(.CYCLES(SOFT_CYC)) uSoft (.clk(clk), .rst(rst), .tif(tSoft));
  remc_timer #(.CYCLES(OC_CYC))   uOc   (.clk(clk), .rst(rst), .tif(tOc));

  remc_state_e state_r;
  remc_state_e state_nxt;

  logic ready;
  logic regulating;
  logic ocTrip;
  logic hazardTrip;
  logic hazardNow;

  assign ready       = !(state_r inside {ST_OFF, ST_BIAS});
  assign regulating  = state_r inside {ST_SOFT, ST_RUN};
  assign tBias.run   = state_r == ST_BIAS;
  assign tSoft.run   = state_r == ST_SOFT;
  assign tOc.run     = regulating && limitHit;
  assign ocTrip      = tOc.done;
  assign hazardTrip  = overTemp || supplyLow || ocTrip;
  // limit hits vanish once switching stops, so the live level ends the trip
  assign hazardNow   = overTemp || supplyLow || limitHit;

  // ********************************************************************
  // configuration registers, back to their reset values whenever the enable pin is low
  // ********************************************************************
  logic               regOn_r;
  logic               fpwmBit_r;
  logic [LIM_W-1:0]   limSel_r;
  logic [LEVEL_W-1:0] lowSet_r;
  logic [LEVEL_W-1:0] highSet_r;
  logic [FUNC_W-1:0]  func_r;
  logic [FLAG_W-1:0]  mask_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regOn_r   <= RST_REG_ON;
      fpwmBit_r <= RST_FORCED_PWM_MODE;
      limSel_r  <= RST_LIM;
      lowSet_r  <= RST_LOW;
      highSet_r <= RST_HIGH;
      func_r    <= FUNC_DEF;
      mask_r    <= RST_MASK;
    end else if (!enPin) begin
      regOn_r   <= RST_REG_ON;
      fpwmBit_r <= RST_FORCED_PWM_MODE;
      limSel_r  <= RST_LIM;
      lowSet_r  <= RST_LOW;
      highSet_r <= RST_HIGH;
      func_r    <= FUNC_DEF;
      mask_r    <= RST_MASK;
    end else if (cfgWrite && ready) begin
      regOn_r   <= regulationOnBit;
      fpwmBit_r <= forcedPwmBit;
      limSel_r  <= switchPeakLimit;
      lowSet_r  <= levelLowSetting;
      highSet_r <= levelHighSetting;
      func_r    <= pinFuncSel;
      mask_r    <= intMaskIn;
    end
  end

  // ********************************************************************
  // power sequencer
  // ********************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OFF:  if (enPin) state_nxt = ST_BIAS;
      ST_BIAS: if (tBias.done) state_nxt = ST_IDLE;
      ST_IDLE: if (regOn_r && !hazardNow) state_nxt = ST_SOFT;
      ST_SOFT: begin
        if (hazardTrip) state_nxt = ST_TRIP;
        else if (!regOn_r) state_nxt = ST_IDLE;
        else if (tSoft.done) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (hazardTrip) state_nxt = ST_TRIP;
        else if (!regOn_r) state_nxt = ST_IDLE;
      end
      ST_TRIP: if (!hazardNow) state_nxt = ST_IDLE;
      default: state_nxt = ST_OFF;
    endcase
    if (!enPin) state_nxt = ST_OFF;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ********************************************************************
  // output level pin latch
  // ********************************************************************
  logic levelLatch_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      levelLatch_r <= 1'b0;
    end else if (state_r == ST_OFF && enPin) begin
      levelLatch_r <= mfpIn;
    end
  end

  // ********************************************************************
  // power-good hysteresis
  // ********************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outputGood_r <= 1'b0;
    end else if (!regulating) begin
      outputGood_r <= 1'b0;
    end else if (aboveGoodRise) begin
      outputGood_r <= 1'b1;
    end else if (belowGoodFall) begin
      outputGood_r <= 1'b0;
    end
  end

  // ********************************************************************
  // interrupt flags
  // ********************************************************************
  logic [FLAG_W-1:0] flags_r;
  logic [FLAG_W-1:0] prev_r;
  logic [FLAG_W-1:0] now;
  logic [FLAG_W-1:0] events;
  logic              readBegin;
  logic              readEnd;
  logic              intRelease_r;
  logic              intActive;

  always_comb begin
    now            = '0;
    now[FLAG_OV]   = overVolt;
    now[FLAG_OC]   = ocTrip;
    now[FLAG_GOOD] = outputGood_r;
    now[FLAG_TEMP] = overTemp;
  end

  // power-good reports both directions, the others only their onset
  assign events    = (now & ~prev_r) |
                     ((now ^ prev_r) & (FLAG_W'(1) << FLAG_GOOD));
  assign readBegin = flagReadStart && ready;
  assign readEnd   = flagReadDone && ready;
  assign intActive = |(flags_r & ~mask_r) && !intRelease_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_r <= '0;
    end else begin
      prev_r <= now;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_r <= '0;
    end else if (!enPin) begin
      flags_r <= '0;
    end else begin
      // a new event wins over the clear of the same cycle
      flags_r <= (readEnd ? '0 : flags_r) | events;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flagReadData_r <= '0;
    end else if (!enPin) begin
      flagReadData_r <= '0;
    end else if (readBegin) begin
      flagReadData_r <= flags_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intRelease_r <= 1'b0;
    end else if (!enPin) begin
      intRelease_r <= 1'b0;
    end else if (readBegin) begin
      intRelease_r <= 1'b1;
    end else if (|events) begin
      intRelease_r <= 1'b0;
    end
  end

  // ********************************************************************
  // output registers
  // ********************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accessReady_r     <= 1'b0;
      biasOn_r          <= 1'b0;
      regulatorOn_r     <= 1'b0;
      softStartDone_r   <= 1'b0;
      forcedPwmMode_r   <= 1'b0;
      peakLimitSelect_r <= RST_LIM;
      targetLevel_r     <= RST_LOW;
    end else begin
      accessReady_r     <= ready;
      biasOn_r          <= state_r != ST_OFF;
      regulatorOn_r     <= regulating && enPin;
      softStartDone_r   <= state_r == ST_RUN;
      forcedPwmMode_r   <= (func_r == FUNC_PWM) ? mfpIn : fpwmBit_r;
      if (func_r == FUNC_LIMIT) begin
        peakLimitSelect_r <= mfpIn ? LIM_HIGH : LIM_LOW;
      end else begin
        peakLimitSelect_r <= limSel_r;
      end
      if (func_r == FUNC_LEVEL) begin
        // pin ignored until the ramp has finished
        if (state_r == ST_RUN ? mfpIn : levelLatch_r) begin
          targetLevel_r <= highSet_r;
        end else begin
          targetLevel_r <= lowSet_r;
        end
      end else begin
        targetLevel_r <= lowSet_r;
      end
    end
  end

  // ********************************************************************
  // multifunction pin, open drain only: output value is always low
  // ********************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mfpOut_r      <= 1'b0;
      mfpOeN_r      <= 1'b1;
      mfpPullDown_r <= 1'b0;
    end else begin
      mfpOut_r      <= 1'b0;
      mfpPullDown_r <= func_r inside {FUNC_PWM, FUNC_LIMIT, FUNC_LEVEL};
      unique case (func_r)
        FUNC_GOOD: mfpOeN_r <= outputGood_r;
        FUNC_INT:  mfpOeN_r <= !intActive;
        default:   mfpOeN_r <= 1'b1;
      endcase
    end
  end

  // ********************************************************************
  // I2C pins: released in the off state and during bias settling
  // ********************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdaOut_r <= 1'b0;
      sdaOeN_r <= 1'b1;
      sclOeN_r <= 1'b1;
    end else begin
      sdaOut_r <= 1'b0;
      sdaOeN_r <= !(sdaDriveLow && ready && enPin);
      sclOeN_r <= 1'b1;
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_biasDone;
    state_r == ST_BIAS && tBias.done && enPin;
  endsequence
  sequence s_softDone;
    state_r == ST_SOFT && tSoft.done && enPin && regOn_r && !hazardTrip;
  endsequence

  property p_biasReady;
    s_biasDone |=> state_r == ST_IDLE ##1 accessReady_r;
  endproperty
  a_biasReady: assert property (p_biasReady) else $error("bias done not ready");

  property p_noEarlyWrite;
    (state_r == ST_BIAS && enPin && cfgWrite) |=> $stable(lowSet_r) && $stable(func_r);
  endproperty
  a_noEarlyWrite: assert property (p_noEarlyWrite) else $error("early write taken");

  property p_softRun;
    s_softDone |=> state_r == ST_RUN ##1 softStartDone_r;
  endproperty
  a_softRun: assert property (p_softRun) else $error("soft-start end missed");

  property p_pinLowReset;
    !enPin |=> regOn_r && func_r == FUNC_DEF && flags_r == '0 && state_r == ST_OFF;
  endproperty
  a_pinLowReset: assert property (p_pinLowReset) else $error("reset on pin low");

  property p_offFollows;
    !enPin ##1 !enPin |=> !regulatorOn_r && !biasOn_r;
  endproperty
  a_offFollows: assert property (p_offFollows) else $error("device not off");

  property p_trip;
    (regulating && enPin && overTemp) |=> state_r == ST_TRIP ##1 !regulatorOn_r;
  endproperty
  a_trip: assert property (p_trip) else $error("no trip on hazard");

  property p_tripHold;
    (state_r == ST_TRIP && hazardNow && enPin) |=> state_r == ST_TRIP;
  endproperty
  a_tripHold: assert property (p_tripHold) else $error("trip left early");

  property p_limitPin;
    (func_r == FUNC_LIMIT && $stable(func_r)) |=>
      peakLimitSelect_r == ($past(mfpIn) ? LIM_HIGH : LIM_LOW);
  endproperty
  a_limitPin: assert property (p_limitPin) else $error("limit pin ignored");

  property p_levelLatch;
    (func_r == FUNC_LEVEL && state_r == ST_SOFT && $stable(func_r) && $stable(highSet_r)
     && $stable(lowSet_r)) |=>
      targetLevel_r == ($past(levelLatch_r) ? $past(highSet_r) : $past(lowSet_r));
  endproperty
  a_levelLatch: assert property (p_levelLatch) else $error("level pin not latched");

  property p_intDrive;
    (func_r == FUNC_INT && intActive) |=> !mfpOeN_r && !mfpOut_r;
  endproperty
  a_intDrive: assert property (p_intDrive) else $error("interrupt not driven");

  property p_intRelease;
    (func_r == FUNC_INT && readBegin && enPin) ##1 (func_r == FUNC_INT && !(|events))
      |=> mfpOeN_r;
  endproperty
  a_intRelease: assert property (p_intRelease) else $error("pin not released");

  property p_flagSetWins;
    (enPin && readEnd && events[FLAG_OV]) |=> flags_r[FLAG_OV];
  endproperty
  a_flagSetWins: assert property (p_flagSetWins) else $error("event lost");

  property p_i2cHiz;
    (state_r == ST_OFF) |=> sdaOeN_r && sclOeN_r;
  endproperty
  a_i2cHiz: assert property (p_i2cHiz) else $error("I2C driven when off");

endmodule : remc_top
`default_nettype wire

// [dv/remc_board.sv]
/*
  Board side of the multifunction pin: pull-up plus an optional driver.
  Assumes the block pulls the pin low only through its enable, active low.
*/
`timescale 1ns/100ps
`default_nettype none
module remc_board (
  // block side
  input  wire logic oeN,
  // board driver
  input  wire logic drv,
  input  wire logic drvVal,
  // resolved level
  output logic      pinLvl
);
  // open-drain low wins; otherwise the board driver, else the pull-up
  assign pinLvl = !oeN ? 1'b0 : (drv ? drvVal : 1'b1);
endmodule : remc_board
`default_nettype wire

// [dv/test_remc_top.sv]
/*
  Self-checking bench for the regulator enable and multifunction pin block.
  Assumes shortened counts: bias 8, soft-start 16, limit persistence 12.
*/
`timescale 1ns/100ps
`default_nettype none
module test_remc_top;
  import remc_pkg::*;
  localparam int BIAS = 8;
  localparam int SOFT = 16;
  localparam int OCC  = 12;
  logic clk = 0, rst = 1, enPin = 0, overTemp = 0, limitHit = 0, overVolt = 0;
  logic supLow = 0;
  logic aboveGoodRise = 0, belowGoodFall = 0, cfgWrite = 0, regOn = 1, forced_pwm_mode = 0;
  logic [1:0] lim = 0;
  logic [6:0] lo = 0, hi = 0;
  logic [2:0] fn = 1;
  logic [3:0] msk = 0, rdData;
  logic rdStart = 0, rdDone = 0, sdaDriveLow = 1, drv = 1, dv = 1, pinLvl;
  logic sdaOut, sdaOeN, sclOeN, mfpOut, mfpOeN, pullDn, ready, biasOn, regOnOut;
  logic ssDone, fpwmMode, good;
  logic [1:0] limSel;
  logic [6:0] level;
  int failures = 0, checked = 0;
  always #10 clk = ~clk;
  remc_top #(.BIAS_CYC(BIAS), .SOFT_CYC(SOFT), .OC_CYC(OCC)) i_remc_top (
    .clk(clk), .rst(rst), .enPin(enPin), .overTemp(overTemp), .supplyLow(supLow),
    .limitHit(limitHit), .overVolt(overVolt), .aboveGoodRise(aboveGoodRise),
    .belowGoodFall(belowGoodFall), .cfgWrite(cfgWrite), .regulationOnBit(regOn),
    .forcedPwmBit(forced_pwm_mode), .switchPeakLimit(lim), .levelLowSetting(lo),
    .levelHighSetting(hi), .pinFuncSel(fn), .intMaskIn(msk),
    .flagReadStart(rdStart), .flagReadDone(rdDone), .flagReadData_r(rdData),
    .sdaDriveLow(sdaDriveLow), .sdaOut_r(sdaOut), .sdaOeN_r(sdaOeN),
    .sclOeN_r(sclOeN), .mfpIn(pinLvl), .mfpOut_r(mfpOut), .mfpOeN_r(mfpOeN),
    .mfpPullDown_r(pullDn), .accessReady_r(ready), .biasOn_r(biasOn),
    .regulatorOn_r(regOnOut), .softStartDone_r(ssDone), .forcedPwmMode_r(fpwmMode),
    .peakLimitSelect_r(limSel), .targetLevel_r(level), .outputGood_r(good));
  remc_board i_remc_board (.oeN(mfpOeN), .drv(drv), .drvVal(dv), .pinLvl(pinLvl));
  // ******************************************************************
  // access tasks
  // ******************************************************************
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // all fields travel together in one strobe
  task cfg(input logic r, input logic [1:0] l, input logic [2:0] f, input logic [3:0] m);
    regOn = r; lim = l; fn = f; msk = m; cfgWrite = 1;
    tick(1);
    cfgWrite = 0;
    tick(3);
  endtask : cfg
  // ev raises the overvoltage level in the very cycle of the clearing strobe
  task flag_read(output logic [3:0] d, output logic o, input logic ev);
    rdStart = 1;
    tick(1);
    rdStart = 0;
    tick(2);
    d = rdData;
    o = mfpOeN;
    rdDone = 1;
    if (ev) overVolt = 1;
    tick(1);
    rdDone = 0;
    tick(2);
  endtask : flag_read
  task close_out;
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  // ******************************************************************
  // tests
  // ******************************************************************
  initial begin
    logic [3:0] d;
    logic       o;
    lo = 7'h11; hi = 7'h22;
    repeat (16) @(posedge clk);
    chk({sdaOeN, sclOeN, mfpOeN, limSel}, 8'h1f);
    #1 rst = 0;
    cfg(0, 1, 7, 1);
    chk({sdaOeN, sclOeN, regOnOut, limSel}, 8'h1b);
    enPin = 1;
    tick(BIAS);
    chk(ready, 0);
    tick(4);
    chk({ready, biasOn, sdaOeN, sclOeN}, 8'hd);
    cfg(0, 1, 3, 0);
    chk(regOnOut, 0);
    dv = 0;
    cfg(1, 1, 3, 0);
    chk({regOnOut, level}, 8'ha2);
    tick(8);
    chk(ssDone, 0);
    tick(12);
    chk(ssDone, 8'h1);
    chk({level, pullDn}, 8'h23);
    dv = 1;
    tick(3);
    chk(level, 8'h22);
    forced_pwm_mode = 1;
    cfg(1, 1, 1, 0);
    chk(limSel, 8'h1);
    for (int v = 0; v < 2; v++) begin
      dv = v[0];
      tick(3);
      chk(fpwmMode, {7'h0, v[0]});
      cfg(1, 1, 2, 0);
      chk(limSel, v[0] ? 8'h3 : 8'h0);
      cfg(1, 1, 1, 0);
    end
    drv = 0;
    cfg(1, 1, 4, 0);
    chk(fpwmMode, 8'h1);
    aboveGoodRise = 1;
    tick(3);
    chk({good, mfpOeN, pullDn, pinLvl}, 8'hd);
    aboveGoodRise = 0; belowGoodFall = 1;
    tick(3);
    chk({good, mfpOeN, pinLvl}, 8'h0);
    cfg(1, 1, 5, 0);
    flag_read(d, o, 0);
    chk({d, o}, 8'h9);
    overVolt = 1;
    tick(3);
    chk({mfpOeN, pinLvl, pullDn}, 8'h0);
    chk({sdaOut, mfpOut}, 8'h0);
    flag_read(d, o, 0);
    chk({d, o}, 8'h3);
    overVolt = 0;
    flag_read(d, o, 1);
    chk(d, 8'h0);
    cfg(1, 1, 5, 1);
    overVolt = 1;
    tick(3);
    chk(mfpOeN, 1);
    flag_read(d, o, 0);
    chk(d, 8'h1);
    // undefined codes must float the pin with no pull-down
    for (int i = 0; i < 3; i++) begin
      cfg(1, 1, (i == 0) ? 3'h0 : 3'(i + 5), 0);
      chk({mfpOeN, pullDn}, 8'h2);
    end
    overTemp = 1;
    tick(3);
    chk(regOnOut, 0);
    tick(30);
    chk(regOnOut, 0);
    overTemp = 0;
    tick(5);
    chk(regOnOut, 1);
    supLow = 1;
    tick(3);
    chk(regOnOut, 0);
    supLow = 0;
    tick(5);
    chk(regOnOut, 1);
    limitHit = 1;
    tick(OCC - 6);
    chk(regOnOut, 1);
    tick(12);
    chk(regOnOut, 0);
    limitHit = 0;
    enPin = 0;
    tick(3);
    chk({regOnOut, biasOn, sdaOeN, limSel, pullDn}, 8'hf);
    chk(level, 8'h0);
    close_out();
  end
  initial begin
    #100000;
    failures++;
    close_out();
  end
endmodule : test_remc_top
`default_nettype wire
